// *** opcr_pkg.sv ***
// Purpose: constants and state types for the output pin configuration bytes
// Assumes: byte-wide register port, one clock, async active-low reset
// Notes:   field positions are bit offsets inside each configuration byte
package opcr_pkg;

   // ----------------------------------------------------------------
   // register byte addresses
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_OUTPUT_IMPEDANCE_CTRL_A  = 8'h0C;
   localparam logic [7:0] ADDR_OUTPUT_IMPEDANCE_CTRL_B  = 8'h0D;
   localparam logic [7:0] ADDR_ENABLE_PIN_PULL_CTRL_A   = 8'h0E;
   localparam logic [7:0] ADDR_ENABLE_PIN_PULL_CTRL_B   = 8'h0F;
   localparam logic [7:0] ADDR_MODE_PIN_PULL_CTRL       = 8'h10;
   localparam logic [7:0] ADDR_RESERVED_CTRL            = 8'h11;
   localparam logic [7:0] ADDR_ENABLE_POLARITY_CTRL     = 8'h12;
   localparam logic [7:0] ADDR_POWERDOWN_POLARITY_CTRL  = 8'h13;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int FLD_POS_A    = 2;
   localparam int FLD_POS_B    = 6;
   localparam int FLD_POS_C    = 0;
   localparam int FLD_POS_D    = 4;
   localparam int FLD_POS_MODE = 2;
   localparam int FLD_POS_PG   = 0;
   localparam int POL_POS_A    = 1;
   localparam int POL_POS_B    = 3;
   localparam int POL_POS_C    = 4;
   localparam int POL_POS_D    = 6;
   localparam int PD_POL_POS   = 0;

   // fixed read value of reserved bits, byte by byte
   localparam logic [7:0] RSVD_VAL_ENABLE_PULL_B = 8'h04;
   localparam logic [7:0] RSVD_VAL_ZERO          = 8'h00;

   // ----------------------------------------------------------------
   // codes and reset values
   // ----------------------------------------------------------------
   localparam logic [1:0] IMP_33_OHM   = 2'h0;
   localparam logic [1:0] IMP_85_OHM   = 2'h1;
   localparam logic [1:0] IMP_100_OHM  = 2'h2;
   localparam logic [1:0] PULL_NONE    = 2'h0;
   localparam logic [1:0] PULL_DOWN    = 2'h1;
   localparam logic [1:0] PULL_UP      = 2'h2;
   localparam logic [1:0] PULL_BOTH    = 2'h3;
   localparam logic [1:0] DEF_CODE_100 = 2'h2;
   localparam logic [1:0] DEF_CODE_85  = 2'h1;
   localparam logic       POL_RESET    = 1'b0;

   // device variant, chosen at build time
   localparam logic [1:0] VAR_100  = 2'h0;
   localparam logic [1:0] VAR_85   = 2'h1;
   localparam logic [1:0] VAR_PROG = 2'h2;

   // pin index order for pull fields: enables a..d, mode pin, powergood pin
   localparam int NUM_OUT  = 4;
   localparam int NUM_PINS = 6;
   localparam int PIN_MODE = 4;
   localparam int PIN_PG   = 5;

   typedef struct packed {
      logic [NUM_OUT-1:0][1:0]  imp;
      logic [NUM_PINS-1:0][1:0] pull;
      logic [NUM_OUT-1:0]       oe_pol;
      logic                     pd_pol;
      logic                     load_pend;
      logic [7:0]               rdata;
      logic [NUM_OUT-1:0]       z33;
      logic [NUM_OUT-1:0]       z85;
      logic [NUM_OUT-1:0]       z100;
   } opcr_state_t;

   typedef struct packed {
      logic pull_up_en;
      logic pull_down_en;
      logic pin_active;
   } opcr_pin_state_t;

endpackage

// *** opcr_pin_ctrl.sv ***
// Purpose: per control pin, resistor enables and active-level detection
// Assumes: pin level synchronous to clk_sys
// Notes:   all outputs registered, one cycle behind their inputs
`timescale 1ns/100ps
`default_nettype none
module opcr_pin_ctrl
   import opcr_pkg::*;
(
   // clock and reset
   input  wire logic       clk_sys,
   input  wire logic       reset_n,
   // configuration
   input  wire logic [1:0] pull_sel,
   input  wire logic       polarity,
   // pin
   input  wire logic       pin_level,
   // results
   output logic            pull_up_en,
   output logic            pull_down_en,
   output logic            pin_active
);

   opcr_pin_state_t s;
   opcr_pin_state_t next_s;

   always_comb begin
      next_s = s;
      next_s.pull_up_en   = (pull_sel == PULL_UP) || (pull_sel == PULL_BOTH);
      next_s.pull_down_en = (pull_sel == PULL_DOWN) || (pull_sel == PULL_BOTH);
      next_s.pin_active   = (pin_level == polarity);
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign pull_up_en   = s.pull_up_en;
   assign pull_down_en = s.pull_down_en;
   assign pin_active   = s.pin_active;

endmodule
`default_nettype wire

// *** opcr_regs.sv ***
// Purpose: configuration bytes for output impedance, pin pulls and polarity
// Assumes: byte register port driven by the management-bus front end
// Notes:   reads return data one cycle after the read strobe
`timescale 1ns/100ps
`default_nettype none
module opcr_regs
   import opcr_pkg::*;
#(
   parameter logic [1:0] VARIANT = VAR_100
)(
   // clock and reset
   input  wire logic                  clk_sys,
   input  wire logic                  reset_n,
   // register port
   input  wire logic [7:0]            reg_addr,
   input  wire logic                  reg_wr_en,
   input  wire logic [7:0]            reg_wdata,
   input  wire logic                  reg_rd_en,
   output logic      [7:0]            reg_rdata,
   // factory defaults and restore control
   input  wire logic [2*NUM_OUT-1:0]  factory_imp,
   input  wire logic [2*NUM_PINS-1:0] factory_pull,
   input  wire logic                  keep_config_in_pd,
   // control pins
   input  wire logic [NUM_OUT-1:0]    enable_pin,
   input  wire logic                  bandwidth_bypass_select_pin,
   input  wire logic                  powergood_powerdown_pin,
   // configured fields
   output logic      [1:0]            out_a_impedance_sel,
   output logic      [1:0]            out_b_impedance_sel,
   output logic      [1:0]            out_c_impedance_sel,
   output logic      [1:0]            out_d_impedance_sel,
   output logic                       enable_a_polarity,
   output logic                       enable_b_polarity,
   output logic                       enable_c_polarity,
   output logic                       enable_d_polarity,
   // derived controls
   output logic      [NUM_OUT-1:0]    drive_33_ohm,
   output logic      [NUM_OUT-1:0]    drive_85_ohm,
   output logic      [NUM_OUT-1:0]    drive_100_ohm,
   output logic      [NUM_PINS-1:0]   pull_up_en,
   output logic      [NUM_PINS-1:0]   pull_down_en,
   output logic      [NUM_OUT-1:0]   output_enable,
   output logic                       power_down
);

   // ----------------------------------------------------------------
   // defaults
   // ----------------------------------------------------------------
   localparam logic [1:0] DEF_CODE = (VARIANT == VAR_85) ? DEF_CODE_85 : DEF_CODE_100;
   localparam logic       IS_PROG  = (VARIANT == VAR_PROG);

   opcr_state_t s;
   opcr_state_t next_s;
   logic [NUM_PINS-1:0] pin_level;
   logic [NUM_PINS-1:0] pin_pol;
   logic [NUM_PINS-1:0] pin_active;

   // place a two-bit field into a byte
   function automatic logic [7:0] put2(input logic [1:0] v, input int pos);
      logic [7:0] b;
      b = 8'h00;
      b[pos+:2] = v;
      return b;
   endfunction

   // pick a default field code, factory value on the programmable variant
   function automatic logic [1:0] dflt(input logic [1:0] factory_code);
      logic [1:0] c;
      c = IS_PROG ? factory_code : DEF_CODE;
      return c;
   endfunction

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      next_s = s;
      // load wins over any write: a cleared config must not be half rewritten
      if (s.load_pend || (power_down && !keep_config_in_pd)) begin
         for (int i = 0; i < NUM_OUT; i++) begin
            next_s.imp[i] = dflt(factory_imp[2*i+:2]);
         end
         for (int i = 0; i < NUM_PINS; i++) begin
            next_s.pull[i] = dflt(factory_pull[2*i+:2]);
         end
         next_s.oe_pol    = {NUM_OUT{POL_RESET}};
         next_s.pd_pol    = POL_RESET;
         next_s.load_pend = 1'b0;
      end else if (reg_wr_en) begin
         // only field bits are stored, so reserved bits drop writes
         case (reg_addr)
            ADDR_OUTPUT_IMPEDANCE_CTRL_A: begin
               next_s.imp[0] = reg_wdata[FLD_POS_A+:2];
               next_s.imp[1] = reg_wdata[FLD_POS_B+:2];
            end
            ADDR_OUTPUT_IMPEDANCE_CTRL_B: begin
               next_s.imp[2] = reg_wdata[FLD_POS_C+:2];
               next_s.imp[3] = reg_wdata[FLD_POS_D+:2];
            end
            ADDR_ENABLE_PIN_PULL_CTRL_A: begin
               next_s.pull[0] = reg_wdata[FLD_POS_A+:2];
               next_s.pull[1] = reg_wdata[FLD_POS_B+:2];
            end
            ADDR_ENABLE_PIN_PULL_CTRL_B: begin
               next_s.pull[2] = reg_wdata[FLD_POS_C+:2];
               next_s.pull[3] = reg_wdata[FLD_POS_D+:2];
            end
            ADDR_MODE_PIN_PULL_CTRL: begin
               next_s.pull[PIN_MODE] = reg_wdata[FLD_POS_MODE+:2];
               next_s.pull[PIN_PG]   = reg_wdata[FLD_POS_PG+:2];
            end
            ADDR_ENABLE_POLARITY_CTRL: begin
               next_s.oe_pol[0] = reg_wdata[POL_POS_A];
               next_s.oe_pol[1] = reg_wdata[POL_POS_B];
               next_s.oe_pol[2] = reg_wdata[POL_POS_C];
               next_s.oe_pol[3] = reg_wdata[POL_POS_D];
            end
            ADDR_POWERDOWN_POLARITY_CTRL: begin
               next_s.pd_pol = reg_wdata[PD_POL_POS];
            end
            default: begin
               // byte 17 and all others hold no function
               next_s.load_pend = s.load_pend;
            end
         endcase
      end

      // read data, reserved bits at their fixed values
      if (reg_rd_en) begin
         case (reg_addr)
            ADDR_OUTPUT_IMPEDANCE_CTRL_A:
               next_s.rdata = put2(s.imp[0], FLD_POS_A) | put2(s.imp[1], FLD_POS_B);
            ADDR_OUTPUT_IMPEDANCE_CTRL_B:
               next_s.rdata = put2(s.imp[2], FLD_POS_C) | put2(s.imp[3], FLD_POS_D);
            ADDR_ENABLE_PIN_PULL_CTRL_A:
               next_s.rdata = put2(s.pull[0], FLD_POS_A) | put2(s.pull[1], FLD_POS_B);
            ADDR_ENABLE_PIN_PULL_CTRL_B:
               next_s.rdata = put2(s.pull[2], FLD_POS_C) | put2(s.pull[3], FLD_POS_D)
                            | RSVD_VAL_ENABLE_PULL_B;
            ADDR_MODE_PIN_PULL_CTRL:
               next_s.rdata = put2(s.pull[PIN_MODE], FLD_POS_MODE)
                            | put2(s.pull[PIN_PG], FLD_POS_PG);
            ADDR_ENABLE_POLARITY_CTRL: begin
               next_s.rdata = RSVD_VAL_ZERO;
               next_s.rdata[POL_POS_A] = s.oe_pol[0];
               next_s.rdata[POL_POS_B] = s.oe_pol[1];
               next_s.rdata[POL_POS_C] = s.oe_pol[2];
               next_s.rdata[POL_POS_D] = s.oe_pol[3];
            end
            ADDR_POWERDOWN_POLARITY_CTRL: begin
               next_s.rdata = RSVD_VAL_ZERO;
               next_s.rdata[PD_POL_POS] = s.pd_pol;
            end
            default:
               next_s.rdata = RSVD_VAL_ZERO;
         endcase
      end

      // drive impedance selects; reserved code keeps the last valid choice
      for (int i = 0; i < NUM_OUT; i++) begin
         case (s.imp[i])
            IMP_33_OHM: begin
               next_s.z33[i]  = 1'b1;
               next_s.z85[i]  = 1'b0;
               next_s.z100[i] = 1'b0;
            end
            IMP_85_OHM: begin
               next_s.z33[i]  = 1'b0;
               next_s.z85[i]  = 1'b1;
               next_s.z100[i] = 1'b0;
            end
            IMP_100_OHM: begin
               next_s.z33[i]  = 1'b0;
               next_s.z85[i]  = 1'b0;
               next_s.z100[i] = 1'b1;
            end
            default: begin
               next_s.z33[i]  = s.z33[i];
               next_s.z85[i]  = s.z85[i];
               next_s.z100[i] = s.z100[i];
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         s           <= '0;
         s.imp       <= {NUM_OUT{DEF_CODE}};
         s.pull      <= {NUM_PINS{DEF_CODE}};
         s.oe_pol    <= {NUM_OUT{POL_RESET}};
         s.pd_pol    <= POL_RESET;
         s.load_pend <= IS_PROG;  // factory values sampled after release
      end else begin
         s <= next_s;
      end
   end

   // ----------------------------------------------------------------
   // control pins
   // ----------------------------------------------------------------
   assign pin_level = {powergood_powerdown_pin, bandwidth_bypass_select_pin, enable_pin};
   // mode pin has no polarity control; its active flag is unused
   assign pin_pol   = {s.pd_pol, 1'b1, s.oe_pol};

   for (genvar p = 0; p < NUM_PINS; p++) begin : g_pin
      opcr_pin_ctrl u_pin (
         .clk_sys      (clk_sys),
         .reset_n      (reset_n),
         .pull_sel     (s.pull[p]),
         .polarity     (pin_pol[p]),
         .pin_level    (pin_level[p]),
         .pull_up_en   (pull_up_en[p]),
         .pull_down_en (pull_down_en[p]),
         .pin_active   (pin_active[p])
      );
   end

   assign output_enable = pin_active[NUM_OUT-1:0];
   assign power_down    = pin_active[PIN_PG];

   assign reg_rdata           = s.rdata;
   assign out_a_impedance_sel = s.imp[0];
   assign out_b_impedance_sel = s.imp[1];
   assign out_c_impedance_sel = s.imp[2];
   assign out_d_impedance_sel = s.imp[3];
   assign enable_a_polarity   = s.oe_pol[0];
   assign enable_b_polarity   = s.oe_pol[1];
   assign enable_c_polarity   = s.oe_pol[2];
   assign enable_d_polarity   = s.oe_pol[3];
   assign drive_33_ohm        = s.z33;
   assign drive_85_ohm        = s.z85;
   assign drive_100_ohm       = s.z100;

endmodule
`default_nettype wire

// *** opcr_regs_properties.sv ***
// Purpose: port-level properties of the output pin configuration bytes
// Assumes: VARIANT 0 or 1 when a write follows reset at once
// Notes:   watches the top module's ports only, attached by bind
`timescale 1ns/100ps
`default_nettype none
module opcr_regs_properties
   import opcr_pkg::*;
#(
   parameter logic [1:0] VARIANT = VAR_100
)(
   // clock and reset
   input wire logic               clk_sys,
   input wire logic               reset_n,
   // register port
   input wire logic [7:0]         reg_addr,
   input wire logic               reg_wr_en,
   input wire logic [7:0]         reg_wdata,
   input wire logic               reg_rd_en,
   input wire logic [7:0]         reg_rdata,
   // pins and fields
   input wire logic               keep_config_in_pd,
   input wire logic [NUM_OUT-1:0] enable_pin,
   input wire logic [1:0]         out_a_impedance_sel,
   input wire logic               enable_a_polarity,
   input wire logic               enable_d_polarity,
   input wire logic [NUM_OUT-1:0] drive_33_ohm,
   input wire logic [NUM_OUT-1:0] drive_85_ohm,
   input wire logic [NUM_OUT-1:0] drive_100_ohm,
   input wire logic [NUM_OUT-1:0] output_enable,
   input wire logic               power_down
);
   localparam logic [1:0] DEF = (VARIANT == VAR_85) ? DEF_CODE_85 : DEF_CODE_100;
   logic reload;
   // reload keys off the registered power-down flag, as the design does
   assign reload = power_down && !keep_config_in_pd;
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!reset_n);
   a_reset_default:
      assert property ($rose(reset_n) |-> out_a_impedance_sel == DEF && !enable_a_polarity)
      else $error("field a not at default after reset");
   a_imp_write:
      assert property (reg_wr_en && reg_addr == ADDR_OUTPUT_IMPEDANCE_CTRL_A && !reload
         |=> out_a_impedance_sel == $past(reg_wdata[3:2]))
      else $error("impedance code a not stored");
   a_drive_sel:
      assert property (out_a_impedance_sel != 2'h3 |=> {drive_100_ohm[0], drive_85_ohm[0],
         drive_33_ohm[0]} == 3'h1 << $past(out_a_impedance_sel))
      else $error("drive select a does not match code");
   a_code11_hold:
      assert property (out_a_impedance_sel == 2'h3 && $past(out_a_impedance_sel) == 2'h3
         |=> $stable(drive_100_ohm[0]) && $stable(drive_85_ohm[0]) && $stable(drive_33_ohm[0]))
      else $error("reserved code changed drive a");
   a_pol_write:
      assert property (reg_wr_en && reg_addr == ADDR_ENABLE_POLARITY_CTRL && !reload
         |=> enable_a_polarity == $past(reg_wdata[1]) && enable_d_polarity == $past(reg_wdata[6]))
      else $error("polarity bits not stored");
   a_oe_follow:
      assert property (enable_pin[0] == enable_a_polarity |=> output_enable[0])
      else $error("output a not enabled at active level");
   a_oe_idle:
      assert property (enable_pin[0] != enable_a_polarity |=> !output_enable[0])
      else $error("output a enabled at inactive level");
   a_rsvd17_read:
      assert property (reg_rd_en && reg_addr == ADDR_RESERVED_CTRL |=> reg_rdata == 8'h00)
      else $error("reserved byte reads nonzero");
   a_rsvd_bits_read:
      assert property (reg_rd_en && reg_addr == ADDR_ENABLE_PIN_PULL_CTRL_B
         |=> reg_rdata[3:2] == 2'h1 && reg_rdata[7:6] == 2'h0)
      else $error("reserved bits of pull byte b read wrong");
   a_pd_reload:
      assert property (reload |=> out_a_impedance_sel == DEF && !enable_a_polarity)
      else $error("config not restored in power-down");
endmodule
bind opcr_regs opcr_regs_properties #(.VARIANT(VARIANT)) i_props (
   .clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
   .reg_wdata(reg_wdata), .reg_rd_en(reg_rd_en), .reg_rdata(reg_rdata),
   .keep_config_in_pd(keep_config_in_pd), .enable_pin(enable_pin),
   .out_a_impedance_sel(out_a_impedance_sel), .enable_a_polarity(enable_a_polarity),
   .enable_d_polarity(enable_d_polarity), .drive_33_ohm(drive_33_ohm),
   .drive_85_ohm(drive_85_ohm), .drive_100_ohm(drive_100_ohm),
   .output_enable(output_enable), .power_down(power_down));
`default_nettype wire

// *** opcr_host.sv ***
// Purpose: management host model driving the byte register port
// Assumes: one strobe pulse per access, answer one cycle later
// Notes:   released address and data show the inverse of the last value
`timescale 1ns/100ps
`default_nettype none
module opcr_host (
   // clock
   input  wire logic      clk_sys,
   // register port
   output var logic [7:0] reg_addr,
   output var logic       reg_wr_en,
   output var logic [7:0] reg_wdata,
   output var logic       reg_rd_en
);
   initial begin
      reg_addr = 8'h00;
      reg_wr_en = 1'b0;
      reg_wdata = 8'h00;
      reg_rd_en = 1'b0;
   end
   task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr_en <= wr;
      reg_rd_en <= !wr;
      @(posedge clk_sys);
      reg_wr_en <= 1'b0;
      reg_rd_en <= 1'b0;
      // stale values must never pass for a fresh request
      reg_addr  <= ~a;
      reg_wdata <= ~d;
   endtask
endmodule
`default_nettype wire

// *** opcr_regs_tb.sv ***
// Purpose: self-checking bench for the output pin configuration bytes
// Assumes: 100 ohm main instance, a programmable one for factory loads
// Notes:   reads are checked from a queue of expected bytes
`timescale 1ns/100ps
`default_nettype none
module opcr_regs_tb
   import opcr_pkg::*;
   ;
   localparam logic [7:0] DFLT [8] = '{8'h88, 8'h22, 8'h88, 8'h26, 8'h0A, 8'h00, 8'h00, 8'h00};
   logic                clk_sys, reset_n, keep, bw_pin, pg_pin, rd_q, reg_wr_en, reg_rd_en;
   logic [7:0]          reg_addr, reg_wdata, reg_rdata, seed;
   logic [3:0]          en_pin, output_enable, d33, d85, d100;
   logic [NUM_PINS-1:0] pull_up_en, pull_down_en;
   logic                power_down;
   logic [1:0]          imp_b;
   logic                pol_b, pol_c;
   wire  [7:0]          p_imp;
   logic [7:0]          exp_q[$];
   int                  miscompares = 0;
   int                  n_compared = 0;
   opcr_host i_host (.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
      .reg_wdata(reg_wdata), .reg_rd_en(reg_rd_en));
   opcr_regs #(.VARIANT(VAR_100)) i_dut (.clk_sys(clk_sys), .reset_n(reset_n),
      .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata),
      .reg_rd_en(reg_rd_en), .reg_rdata(reg_rdata), .factory_imp(8'h00),
      .factory_pull(12'h000), .keep_config_in_pd(keep), .enable_pin(en_pin),
      .bandwidth_bypass_select_pin(bw_pin), .powergood_powerdown_pin(pg_pin),
      .out_a_impedance_sel(), .out_b_impedance_sel(imp_b), .out_c_impedance_sel(),
      .out_d_impedance_sel(), .enable_a_polarity(), .enable_b_polarity(pol_b),
      .enable_c_polarity(pol_c), .enable_d_polarity(), .drive_33_ohm(d33), .drive_85_ohm(d85),
      .drive_100_ohm(d100), .pull_up_en(pull_up_en), .pull_down_en(pull_down_en),
      .output_enable(output_enable), .power_down(power_down));
   // field a kept at the 100 ohm code so the shared checker still holds here
   opcr_regs #(.VARIANT(VAR_PROG)) i_prog (.clk_sys(clk_sys), .reset_n(reset_n),
      .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata),
      .reg_rd_en(reg_rd_en), .reg_rdata(), .factory_imp(8'h4E),
      .factory_pull(12'h000), .keep_config_in_pd(keep), .enable_pin(en_pin),
      .bandwidth_bypass_select_pin(bw_pin), .powergood_powerdown_pin(pg_pin),
      .out_a_impedance_sel(p_imp[1:0]), .out_b_impedance_sel(p_imp[3:2]),
      .out_c_impedance_sel(p_imp[5:4]), .out_d_impedance_sel(p_imp[7:6]),
      .enable_a_polarity(), .enable_b_polarity(), .enable_c_polarity(),
      .enable_d_polarity(), .drive_33_ohm(), .drive_85_ohm(), .drive_100_ohm(),
      .pull_up_en(), .pull_down_en(), .output_enable(), .power_down());
   always #2.5 clk_sys = ~clk_sys;
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      i_host.access(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      i_host.access(1'b0, a, 8'h00);
   endtask
   task automatic end_of_test();
      $display("compared %0d mismatched %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // --------------------------------------------------------------
   // read monitor: data is due one cycle after the strobe
   // --------------------------------------------------------------
   always @(posedge clk_sys) begin
      if (rd_q === 1'b1) begin
         if (exp_q.size() == 0) begin
            cmp(reg_rdata, 8'hxx);
         end else begin
            cmp(reg_rdata, exp_q.pop_front());
         end
      end
      rd_q <= reg_rd_en;
   end
   initial begin
      repeat (5000) @(posedge clk_sys);
      miscompares++;
      end_of_test();
   end
   initial begin
      clk_sys = 1'b0;
      reset_n = 1'b0;
      keep = 1'b1;
      en_pin = 4'h0;
      bw_pin = 1'b0;
      pg_pin = 1'b1;
      seed = 8'h22;
      repeat (3) @(posedge clk_sys);
      reset_n <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         rd(ADDR_OUTPUT_IMPEDANCE_CTRL_A + 8'(i), DFLT[i]);
      end
      rd(8'h20, 8'h00);
      @(negedge clk_sys);
      cmp({2'h0, pull_up_en}, 8'h3F);
      cmp({2'h0, pull_down_en}, 8'h00);
      cmp(p_imp, 8'h4E);
      for (int c = 0; c < 4; c++) begin
         wr(ADDR_OUTPUT_IMPEDANCE_CTRL_A, {2'(c), 2'h3, 2'(c), 2'h3});
         rd(ADDR_OUTPUT_IMPEDANCE_CTRL_A, {2'(c), 2'h0, 2'(c), 2'h0});
         @(negedge clk_sys);
         // reserved code keeps the 100 ohm drive left by code 2
         cmp({2'h0, d100[1:0], d85[1:0], d33[1:0]}, 8'h03 << (2 * ((c == 3) ? 2 : c)));
         cmp({6'h00, imp_b}, {6'h00, 2'(c)});
      end
      for (int c = 0; c < 4; c++) begin
         wr(ADDR_ENABLE_PIN_PULL_CTRL_A, {6'h00, 2'(c)} << 2);
         repeat (2) @(posedge clk_sys);
         @(negedge clk_sys);
         cmp({6'h00, pull_up_en[0], pull_down_en[0]}, {6'h00, 2'(c)});
      end
      wr(ADDR_RESERVED_CTRL, 8'hFF);
      rd(ADDR_RESERVED_CTRL, 8'h00);
      wr(ADDR_ENABLE_PIN_PULL_CTRL_B, 8'hFF);
      rd(ADDR_ENABLE_PIN_PULL_CTRL_B, 8'h37);
      for (int i = 0; i < 8; i++) begin
         seed = lfsr(seed);
         wr(ADDR_ENABLE_POLARITY_CTRL, seed);
         en_pin <= seed[7:4] ^ seed[3:0];
         bw_pin <= seed[0];
         rd(ADDR_ENABLE_POLARITY_CTRL, seed & 8'h5A);
         @(negedge clk_sys);
         cmp({4'h0, output_enable}, {4'h0, ~(en_pin ^ {seed[6], seed[4], seed[3], seed[1]})});
         cmp({6'h00, pol_c, pol_b}, {6'h00, seed[4], seed[3]});
      end
      wr(ADDR_POWERDOWN_POLARITY_CTRL, 8'hFF);
      rd(ADDR_POWERDOWN_POLARITY_CTRL, 8'h01);
      @(negedge clk_sys);
      cmp({7'h00, power_down}, 8'h01);
      @(posedge clk_sys);
      pg_pin <= 1'b0;
      repeat (2) @(posedge clk_sys);
      @(negedge clk_sys);
      cmp({7'h00, power_down}, 8'h00);
      // clearing keep any earlier would reload the polarity under the check above
      @(posedge clk_sys);
      keep <= 1'b0;
      wr(ADDR_OUTPUT_IMPEDANCE_CTRL_A, 8'h44);
      wr(ADDR_POWERDOWN_POLARITY_CTRL, 8'h00);
      repeat (2) @(posedge clk_sys);
      rd(ADDR_OUTPUT_IMPEDANCE_CTRL_A, 8'h88);
      wr(ADDR_OUTPUT_IMPEDANCE_CTRL_A, 8'h44);
      rd(ADDR_OUTPUT_IMPEDANCE_CTRL_A, 8'h88);
      pg_pin <= 1'b1;
      repeat (3) @(posedge clk_sys);
      wr(ADDR_OUTPUT_IMPEDANCE_CTRL_A, 8'h44);
      rd(ADDR_OUTPUT_IMPEDANCE_CTRL_A, 8'h44);
      // let the monitor take the read data before reset clears it
      @(posedge clk_sys);
      reset_n <= 1'b0;
      repeat (3) @(posedge clk_sys);
      reset_n <= 1'b1;
      rd(ADDR_OUTPUT_IMPEDANCE_CTRL_A, 8'h88);
      repeat (2) @(posedge clk_sys);
      if (exp_q.size() != 0) begin
         miscompares++;
      end
      end_of_test();
   end
endmodule
`default_nettype wire
